//--- design/multimode_timer_set.sv
// Purpose: Two 16-bit and three 8-bit down counters with measurement modes
// Assumes: Pins are asynchronous and pass two flip-flops before use
// Notes:   Interrupt requests leave as one-cycle registered pulses
`timescale 1ns/1ps
`default_nettype none
module multimode_timer_set (
   input  wire logic                     ref_clk,
   input  wire logic                     reset_n,
   input  wire logic                     event_pin_a,
   input  wire logic                     event_pin_b,
   input  wire timer_set_pkg::tx_ctrl_s  tx_ctrl,
   input  wire timer_set_pkg::ty_ctrl_s  ty_ctrl,
   input  wire timer_set_pkg::t8_ctrl_s  t8_ctrl,
   input  wire logic                     tx_wr,
   input  wire logic [15:0]              tx_wdata,
   input  wire logic                     ty_wr,
   input  wire logic [15:0]              ty_wdata,
   input  wire logic                     ty_rd,
   input  wire logic                     t1_wr,
   input  wire logic                     t2_wr,
   input  wire logic                     t3_wr,
   input  wire logic [7:0]               t8_wdata,
   output logic [15:0]                   tx_count,
   output logic [15:0]                   ty_rdata,
   output logic [7:0]                    t1_count,
   output logic [7:0]                    t2_count,
   output logic [7:0]                    t3_count,
   output timer_set_pkg::irq_s           irq,
   output logic                          rt_port_bit_lo,
   output logic                          rt_port_bit_hi,
   output logic                          timer2_toggle_out
);
   import timer_set_pkg::*;

   function automatic logic [7:0] t8_next(input logic [7:0] cnt, input logic [7:0] lat,
                                          input logic en, input logic load,
                                          input logic [7:0] wdata);
      if (load)
         return wdata;
      if (en)
         return (cnt == CNT8_ZERO) ? lat : cnt - CNT8_ONE;
      return cnt;
   endfunction : t8_next

   logic [7:0]  pre_r;
   logic [2:0]  a_sync_r, b_sync_r;
   logic [15:0] tx_cnt_r, tx_lat_r, ty_cnt_r, ty_lat_r, ty_snap_r, ty_rdata_r;
   logic        ty_hold_r, rt_en_r, timer2_toggle_out_r;
   logic [1:0]  rt_out_r;
   logic [7:0]  t1_cnt_r, t1_lat_r, t2_cnt_r, t2_lat_r, t3_cnt_r, t3_lat_r;
   irq_s        irq_r;
   logic        pre16, pre256;
   logic        a_lvl, a_rise, a_fall, a_edge, b_rise, b_fall, b_sel, b_irq_ev;
   logic        tx_en, tx_uf, ty_meas, ty_reload, ty_en, ty_uf;
   logic        t1_en, t1_uf, t2_en, t2_uf, t3_en, t3_uf, t2_load;

   // Free-running prescaler gives the divide-by-16 and divide-by-256 enables
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n)
         pre_r <= PRE_RST;
      else
         pre_r <= pre_r + 8'h01;
   end
   assign pre16  = (pre_r[3:0] == PRE_LO_MAX);
   assign pre256 = (pre_r == PRE_HI_MAX);

   // Two stages synchronise, the third only remembers the last level for edges
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         a_sync_r <= 3'h0;
         b_sync_r <= 3'h0;
      end else begin
         a_sync_r <= {a_sync_r[1:0], event_pin_a};
         b_sync_r <= {b_sync_r[1:0], event_pin_b};
      end
   end
   assign a_lvl  = a_sync_r[1];
   assign a_rise = a_sync_r[1] & ~a_sync_r[2];
   assign a_fall = ~a_sync_r[1] & a_sync_r[2];
   assign a_edge = tx_ctrl.edge_sw ? a_fall : a_rise;
   assign b_rise = b_sync_r[1] & ~b_sync_r[2];
   assign b_fall = ~b_sync_r[1] & b_sync_r[2];
   assign b_sel  = ty_ctrl.edge_sw ? b_fall : b_rise;

   // First 16-bit timer
   always_comb begin
      case (tx_ctrl.mode)
         TX_EVENT:  tx_en = a_edge;
         TX_PWIDTH: tx_en = pre16 & (a_lvl == ~tx_ctrl.edge_sw);
         default:   tx_en = pre16;
      endcase
   end
   assign tx_uf = tx_en & (tx_cnt_r == CNT16_ZERO);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n)
         tx_cnt_r <= CNT16_RST;
      else if (tx_wr && (!tx_ctrl.wr_ctrl || tx_uf))
         tx_cnt_r <= tx_wdata;
      else if (tx_uf)
         tx_cnt_r <= tx_lat_r;
      else if (tx_en)
         tx_cnt_r <= tx_cnt_r - CNT16_ONE;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n)
         tx_lat_r <= CNT16_RST;
      else if (tx_wr)
         tx_lat_r <= tx_wdata;
   end

   // Real-time port
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rt_en_r  <= 1'b0;
         rt_out_r <= RT_RST;
      end else begin
         rt_en_r <= tx_ctrl.rt_en;
         if (tx_ctrl.rt_en && (!rt_en_r || tx_uf))
            rt_out_r <= tx_ctrl.rt_data;
      end
   end
   assign rt_port_bit_lo = rt_out_r[0];
   assign rt_port_bit_hi = rt_out_r[1];

   // Second 16-bit timer
   assign ty_meas   = (ty_ctrl.mode == TY_PERIOD) || (ty_ctrl.mode == TY_HL);
   assign b_irq_ev  = (ty_ctrl.mode == TY_HL) ? (b_rise | b_fall) : b_sel;
   assign ty_reload = ty_meas & b_irq_ev;
   assign ty_en     = (ty_ctrl.mode == TY_EVENT) ? b_sel : pre16;
   assign ty_uf     = ty_en & (ty_cnt_r == CNT16_ZERO) & ~ty_reload;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n)
         ty_cnt_r <= CNT16_RST;
      else if (ty_wr)
         ty_cnt_r <= ty_wdata;
      else if (ty_reload || ty_uf)
         ty_cnt_r <= ty_lat_r;
      else if (ty_en)
         ty_cnt_r <= ty_cnt_r - CNT16_ONE;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n)
         ty_lat_r <= CNT16_RST;
      else if (ty_wr)
         ty_lat_r <= ty_wdata;
   end

   // Captured count survives until the first read; a new capture beats the read
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ty_snap_r <= CNT16_ZERO;
         ty_hold_r <= 1'b0;
      end else if (ty_reload && !ty_wr) begin
         ty_snap_r <= ty_cnt_r;
         ty_hold_r <= 1'b1;
      end else if (ty_rd) begin
         ty_hold_r <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n)
         ty_rdata_r <= CNT16_ZERO;
      else if (ty_rd)
         ty_rdata_r <= ty_hold_r ? ty_snap_r : ty_cnt_r;
   end

   // Three 8-bit timers
   assign t1_en   = (t8_ctrl.t1_src == T1_SRC_DIV256) ? pre256 : pre16;
   assign t1_uf   = t1_en & (t1_cnt_r == CNT8_ZERO);
   assign t2_en   = (t8_ctrl.t2_src == T23_SRC_T1UF) ? t1_uf : pre16;
   assign t2_uf   = t2_en & (t2_cnt_r == CNT8_ZERO);
   assign t3_en   = (t8_ctrl.t3_src == T23_SRC_T1UF) ? t1_uf : pre16;
   assign t3_uf   = t3_en & (t3_cnt_r == CNT8_ZERO);
   assign t2_load = t2_wr & (~t8_ctrl.t2_wr_ctrl | t2_uf);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         t1_cnt_r <= CNT8_RST;
         t2_cnt_r <= CNT8_RST;
         t3_cnt_r <= CNT8_RST;
      end else begin
         t1_cnt_r <= t8_next(t1_cnt_r, t1_lat_r, t1_en, t1_wr, t8_wdata);
         t2_cnt_r <= t8_next(t2_cnt_r, t2_lat_r, t2_en, t2_load, t8_wdata);
         t3_cnt_r <= t8_next(t3_cnt_r, t3_lat_r, t3_en, t3_wr, t8_wdata);
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         t1_lat_r <= CNT8_RST;
         t2_lat_r <= CNT8_RST;
         t3_lat_r <= CNT8_RST;
      end else begin
         if (t1_wr)
            t1_lat_r <= t8_wdata;
         if (t2_wr)
            t2_lat_r <= t8_wdata;
         if (t3_wr)
            t3_lat_r <= t8_wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n)
         timer2_toggle_out_r <= 1'b0;
      else if (t8_ctrl.timer2_toggle_out_en && t2_uf)
         timer2_toggle_out_r <= ~timer2_toggle_out_r;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n)
         irq_r <= '0;
      else
         irq_r <= '{tx: tx_uf, ty: ty_uf, t1: t1_uf, t2: t2_uf, t3: t3_uf,
                    pin_a: a_edge, pin_b: b_irq_ev};
   end

   assign tx_count          = tx_cnt_r;
   assign ty_rdata          = ty_rdata_r;
   assign t1_count          = t1_cnt_r;
   assign t2_count          = t2_cnt_r;
   assign t3_count          = t3_cnt_r;
   assign irq               = irq_r;
   assign timer2_toggle_out = timer2_toggle_out_r;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   tx_pwidth_gate_a: assert property ((tx_ctrl.mode == TX_PWIDTH) && !tx_wr
         && (a_lvl == tx_ctrl.edge_sw) |=> $stable(tx_cnt_r))
      else $error("pulse-width count moved at idle level");
   tx_latch_only_a: assert property (tx_wr && tx_ctrl.wr_ctrl && !tx_uf
         |=> tx_cnt_r == $past(tx_cnt_r) || tx_cnt_r == $past(tx_cnt_r) - CNT16_ONE)
      else $error("latch-only write changed counter");
   tx_direct_wr_a: assert property (tx_wr && !tx_ctrl.wr_ctrl
         |=> tx_cnt_r == $past(tx_wdata) && tx_lat_r == $past(tx_wdata))
      else $error("direct write not loaded");
   tx_collide_a: assert property (tx_wr && tx_ctrl.wr_ctrl && tx_uf
         |=> tx_cnt_r == $past(tx_wdata) && tx_lat_r == $past(tx_wdata))
      else $error("write at underflow lost");
   tx_reload_a: assert property (tx_uf && !tx_wr
         |=> tx_cnt_r == $past(tx_lat_r) && irq.tx)
      else $error("first timer reload or request missing");
   tx_event_a: assert property ((tx_ctrl.mode == TX_EVENT) && a_edge && !tx_wr
         && (tx_cnt_r != CNT16_ZERO) |=> tx_cnt_r == $past(tx_cnt_r) - CNT16_ONE)
      else $error("event count step missing");
   rt_update_a: assert property (tx_ctrl.rt_en && (tx_uf || !rt_en_r)
         |=> rt_out_r == $past(tx_ctrl.rt_data))
      else $error("real-time data not output");
   rt_hold_a: assert property (rt_en_r && tx_ctrl.rt_en && !tx_uf |=> $stable(rt_out_r))
      else $error("real-time pins changed between underflows");
   ty_timer_a: assert property ((ty_ctrl.mode == TY_TIMER) && !pre16 && !ty_wr
         |=> $stable(ty_cnt_r))
      else $error("second timer moved off the divided clock");
   ty_reload_a: assert property (ty_reload && !ty_wr
         |=> ty_cnt_r == $past(ty_lat_r) && irq.pin_b)
      else $error("edge reload missing");
   ty_snap_a: assert property (ty_reload && !ty_wr
         |=> ty_hold_r && ty_snap_r == $past(ty_cnt_r))
      else $error("count before reload not captured");
   ty_capture_a: assert property (ty_reload && !ty_wr ##1 ty_rd
         |=> ty_rdata == $past(ty_cnt_r, 2))
      else $error("captured count not returned");
   ty_event_a: assert property ((ty_ctrl.mode == TY_EVENT) && b_sel && !ty_wr
         && (ty_cnt_r != CNT16_ZERO) |=> ty_cnt_r == $past(ty_cnt_r) - CNT16_ONE)
      else $error("pin B event not counted");
   ty_hl_edges_a: assert property ((ty_ctrl.mode == TY_HL)
         && (b_rise || b_fall) |=> irq.pin_b)
      else $error("high/low edge missed");
   ty_uf_a: assert property (ty_uf && !ty_wr
         |=> ty_cnt_r == $past(ty_lat_r) && irq.ty)
      else $error("second timer reload or request missing");
   t1_uf_a: assert property (t1_uf && !t1_wr |=> t1_cnt_r == $past(t1_lat_r) && irq.t1)
      else $error("first 8-bit reload or request missing");
   t3_uf_a: assert property (t3_uf && !t3_wr |=> t3_cnt_r == $past(t3_lat_r) && irq.t3)
      else $error("third 8-bit reload or request missing");
   t2_latch_a: assert property (t2_wr && t8_ctrl.t2_wr_ctrl && !t2_uf
         |=> t2_lat_r == $past(t8_wdata) && (t2_cnt_r == $past(t2_cnt_r)
         || t2_cnt_r == $past(t2_cnt_r) - CNT8_ONE))
      else $error("second 8-bit latch-only write wrong");
   t2_direct_a: assert property (t2_wr && !t8_ctrl.t2_wr_ctrl
         |=> t2_cnt_r == $past(t8_wdata) && t2_lat_r == $past(t8_wdata))
      else $error("second 8-bit direct write not loaded");
   timer2_toggle_out_flip_a: assert property (t8_ctrl.timer2_toggle_out_en && t2_uf |=> timer2_toggle_out_r != $past(timer2_toggle_out_r))
      else $error("toggle output did not invert");
   t2_chain_a: assert property ((t8_ctrl.t2_src == T23_SRC_T1UF) && !t1_uf && !t2_wr
         |=> $stable(t2_cnt_r))
      else $error("second 8-bit counted without first underflow");

   tx_uf_c: cover property (tx_uf ##1 irq.tx);
   ty_reload_c: cover property (ty_reload ##[1:20] ty_rd);
   rt_start_c: cover property (tx_ctrl.rt_en && !rt_en_r);
   timer2_toggle_out_c: cover property (t8_ctrl.timer2_toggle_out_en && t2_uf);
   ty_hl_c: cover property ((ty_ctrl.mode == TY_HL) && b_fall);
endmodule : multimode_timer_set
`default_nettype wire

//--- inc/timer_set_pkg.sv
// Purpose: Shared constants and carriers for the multimode timer set
// Assumes: One 25 MHz clock, all controls are plain ports
// Notes:   Mode codes are 2-bit fields, count widths are fixed
package timer_set_pkg;
   localparam int unsigned CLK_HZ     = 25000000;
   localparam int unsigned PRE_DIV_LO = 16;
   localparam int unsigned PRE_DIV_HI = 256;
   localparam logic [7:0]  PRE_HI_MAX = 8'(PRE_DIV_HI - 1);
   localparam logic [3:0]  PRE_LO_MAX = 4'(PRE_DIV_LO - 1);
   localparam logic [7:0]  PRE_RST    = 8'h00;

   localparam logic [1:0]  TX_TIMER   = 2'h0;
   localparam logic [1:0]  TX_PULSE   = 2'h1;
   localparam logic [1:0]  TX_EVENT   = 2'h2;
   localparam logic [1:0]  TX_PWIDTH  = 2'h3;

   localparam logic [1:0]  TY_TIMER   = 2'h0;
   localparam logic [1:0]  TY_PERIOD  = 2'h1;
   localparam logic [1:0]  TY_EVENT   = 2'h2;
   localparam logic [1:0]  TY_HL      = 2'h3;

   localparam logic        T1_SRC_DIV16  = 1'h0;
   localparam logic        T1_SRC_DIV256 = 1'h1;
   localparam logic        T23_SRC_T1UF  = 1'h0;
   localparam logic        T23_SRC_DIV16 = 1'h1;

   localparam logic [15:0] CNT16_ZERO = 16'h0000;
   localparam logic [15:0] CNT16_ONE  = 16'h0001;
   localparam logic [15:0] CNT16_RST  = 16'hFFFF;
   localparam logic [7:0]  CNT8_ZERO  = 8'h00;
   localparam logic [7:0]  CNT8_ONE   = 8'h01;
   localparam logic [7:0]  CNT8_RST   = 8'hFF;
   localparam logic [1:0]  RT_RST     = 2'h0;

   typedef struct packed {
      logic [1:0] mode;
      logic       edge_sw;
      logic       wr_ctrl;
      logic       rt_en;
      logic [1:0] rt_data;
   } tx_ctrl_s;

   typedef struct packed {
      logic [1:0] mode;
      logic       edge_sw;
   } ty_ctrl_s;

   typedef struct packed {
      logic t1_src;
      logic t2_src;
      logic t3_src;
      logic t2_wr_ctrl;
      logic timer2_toggle_out_en;
   } t8_ctrl_s;

   typedef struct packed {
      logic tx;
      logic ty;
      logic t1;
      logic t2;
      logic t3;
      logic pin_a;
      logic pin_b;
   } irq_s;
endpackage : timer_set_pkg

//--- verification/event_pin_model.sv
// Purpose: Drives the two external event pins of the timer set
// Assumes: Pins are levels, sampled by the block's synchroniser
// Notes:   Each change is held 8 clocks so it passes the sync stages
`timescale 1ns/1ps
`default_nettype none
module event_pin_model (
   input  wire logic ref_clk,
   output logic      event_pin_a,
   output logic      event_pin_b
);
   initial begin
      event_pin_a = 1'b0;
      event_pin_b = 1'b0;
   end
   task automatic set_pin(input logic sel, input logic v);
      @(negedge ref_clk);
      if (sel)
         event_pin_b = v;
      else
         event_pin_a = v;
      repeat (8) @(negedge ref_clk);
   endtask : set_pin
endmodule : event_pin_model
`default_nettype wire

//--- verification/tb_multimode_timer_set.sv
// Purpose: Self-checking bench for the multimode timer set
// Assumes: Inputs change on the falling edge of ref_clk
// Notes:   Interrupt pulses are counted on the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_multimode_timer_set;
   import timer_set_pkg::*;
   logic        ref_clk, reset_n, tx_wr, ty_wr, ty_rd, t1_wr, t2_wr, t3_wr;
   logic        event_pin_a, event_pin_b, rt_port_bit_lo, rt_port_bit_hi;
   logic        timer2_toggle_out;
   logic [15:0] tx_wdata, ty_wdata, tx_count, ty_rdata, r1, r2;
   logic [7:0]  t8_wdata, t1_count, t2_count, t3_count;
   tx_ctrl_s    tx_ctrl;
   ty_ctrl_s    ty_ctrl;
   t8_ctrl_s    t8_ctrl;
   irq_s        irq;
   int          n_errors = 0, n_checks = 0, n_pa = 0, n_pb = 0, n_tx = 0, n_t2 = 0;

   event_pin_model pins (.ref_clk(ref_clk), .event_pin_a(event_pin_a),
                         .event_pin_b(event_pin_b));
   multimode_timer_set uut (.ref_clk(ref_clk), .reset_n(reset_n),
      .event_pin_a(event_pin_a), .event_pin_b(event_pin_b), .tx_ctrl(tx_ctrl),
      .ty_ctrl(ty_ctrl), .t8_ctrl(t8_ctrl), .tx_wr(tx_wr), .tx_wdata(tx_wdata),
      .ty_wr(ty_wr), .ty_wdata(ty_wdata), .ty_rd(ty_rd), .t1_wr(t1_wr),
      .t2_wr(t2_wr), .t3_wr(t3_wr), .t8_wdata(t8_wdata), .tx_count(tx_count),
      .ty_rdata(ty_rdata), .t1_count(t1_count), .t2_count(t2_count),
      .t3_count(t3_count), .irq(irq), .rt_port_bit_lo(rt_port_bit_lo),
      .rt_port_bit_hi(rt_port_bit_hi), .timer2_toggle_out(timer2_toggle_out));

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      if (irq.pin_a === 1'b1) n_pa++;
      if (irq.pin_b === 1'b1) n_pb++;
      if (irq.tx === 1'b1) n_tx++;
      if (irq.t2 === 1'b1) n_t2++;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : report_and_stop

   // Waits for the next underflow pulse of the first 16-bit or second 8-bit timer
   task automatic wait_irq(input bit s);
      int c0;
      c0 = s ? n_t2 : n_tx;
      for (int i = 0; i < 2000; i++) begin
         @(negedge ref_clk);
         if ((s ? n_t2 : n_tx) != c0) return;
      end
      n_errors++;
      report_and_stop();
   endtask : wait_irq

   task automatic wr_tx(input logic [15:0] d);
      tx_wdata = d;
      tx_wr = 1'b1;
      @(negedge ref_clk);
      tx_wr = 1'b0;
   endtask : wr_tx

   task automatic wr_ty(input logic [15:0] d);
      ty_wdata = d;
      ty_wr = 1'b1;
      @(negedge ref_clk);
      ty_wr = 1'b0;
   endtask : wr_ty

   task automatic rd_ty(output logic [15:0] r);
      ty_rd = 1'b1;
      @(negedge ref_clk);
      ty_rd = 1'b0;
      r = ty_rdata;
      @(negedge ref_clk);
   endtask : rd_ty

   task automatic wr8(input int sel, input logic [7:0] d);
      t8_wdata = d;
      t1_wr = (sel == 1);
      t2_wr = (sel == 2);
      t3_wr = (sel == 3);
      @(negedge ref_clk);
      {t1_wr, t2_wr, t3_wr} = 3'h0;
      @(negedge ref_clk);
   endtask : wr8

   initial begin
      {reset_n, tx_wr, ty_wr, ty_rd, t1_wr, t2_wr, t3_wr} = 7'h00;
      {tx_wdata, ty_wdata, t8_wdata} = 40'h0;
      tx_ctrl = '0;
      ty_ctrl = '0;
      t8_ctrl = '0;
      repeat (10) @(negedge ref_clk);
      reset_n = 1'b1;
      check("tx reset", tx_count, 16'hFFFF);
      check("rt reset", 16'({rt_port_bit_hi, rt_port_bit_lo}), 16'h0000);
      // Real-time port around the first 16-bit timer
      wr_tx(16'h0001);
      check("tx direct", tx_count, 16'h0001);
      tx_ctrl.rt_data = 2'h3;
      tx_ctrl.rt_en = 1'b1;
      repeat (3) @(negedge ref_clk);
      check("rt enable", 16'({rt_port_bit_hi, rt_port_bit_lo}), 16'h0003);
      wait_irq(0);
      check("tx reload", tx_count, 16'h0001);
      tx_ctrl.rt_data = 2'h0;
      repeat (3) @(negedge ref_clk);
      check("rt held", 16'({rt_port_bit_hi, rt_port_bit_lo}), 16'h0003);
      wait_irq(0);
      check("rt copy", 16'({rt_port_bit_hi, rt_port_bit_lo}), 16'h0000);
      tx_ctrl.wr_ctrl = 1'b1;
      wr_tx(16'h0005);
      check("tx latch only", 16'(tx_count == 16'h0005), 16'h0000);
      wait_irq(0);
      check("tx latch taken", tx_count, 16'h0005);
      // Pulse-width measurement gated by the first event pin
      tx_ctrl.wr_ctrl = 1'b0;
      tx_ctrl.mode = TX_PWIDTH;
      wr_tx(16'h0100);
      repeat (64) @(negedge ref_clk);
      check("pw gated low", tx_count, 16'h0100);
      pins.set_pin(1'b0, 1'b1);
      check("pin a rise irq", 16'(n_pa), 16'h0001);
      repeat (64) @(negedge ref_clk);
      check("pw counting", 16'(tx_count < 16'h0100), 16'h0001);
      tx_ctrl.edge_sw = 1'b1;
      @(negedge ref_clk);
      r1 = tx_count;
      repeat (64) @(negedge ref_clk);
      check("pw gated high", tx_count, r1);
      pins.set_pin(1'b0, 1'b0);
      check("pin a fall irq", 16'(n_pa), 16'h0002);
      // Event counting on the falling edge of the first pin
      tx_ctrl.mode = TX_EVENT;
      wr_tx(16'h0010);
      pins.set_pin(1'b0, 1'b1);
      pins.set_pin(1'b0, 1'b0);
      check("tx events", tx_count, 16'h000F);
      check("pin a fall only", 16'(n_pa), 16'h0003);
      // Second 16-bit timer: event, both-edge, period and timer modes
      ty_ctrl = '{TY_EVENT, 1'b0};
      wr_ty(16'h0010);
      for (int i = 0; i < 3; i++) begin
         pins.set_pin(1'b1, 1'b1);
         pins.set_pin(1'b1, 1'b0);
      end
      rd_ty(r1);
      check("ty events", r1, 16'h000D);
      check("pin b rise only", 16'(n_pb), 16'h0003);
      ty_ctrl = '{TY_HL, 1'b0};
      pins.set_pin(1'b1, 1'b1);
      pins.set_pin(1'b1, 1'b0);
      check("hl both edges", 16'(n_pb), 16'h0005);
      ty_ctrl = '{TY_PERIOD, 1'b0};
      wr_ty(16'h1000);
      repeat (480) @(negedge ref_clk);
      pins.set_pin(1'b1, 1'b1);
      check("period irq", 16'(n_pb), 16'h0006);
      repeat (160) @(negedge ref_clk);
      rd_ty(r1);
      rd_ty(r2);
      check("capture held", 16'(r1 < r2), 16'h0001);
      check("period reload", 16'(r2 > 16'h0FF0), 16'h0001);
      ty_ctrl = '{TY_TIMER, 1'b0};
      wr_ty(16'h0100);
      repeat (160) @(negedge ref_clk);
      rd_ty(r1);
      check("ty div16", r1, 16'h00F6);
      // 8-bit timers: sources first, then writes in order 1, 2, 3
      t8_ctrl = '{T1_SRC_DIV16, T23_SRC_T1UF, T23_SRC_DIV16, 1'b0, 1'b1};
      wr8(1, 8'h01);
      wr8(2, 8'h02);
      wr8(3, 8'h40);
      check("t2 direct", 16'(t2_count), 16'h0002);
      wait_irq(1);
      check("t2 reload", 16'(t2_count), 16'h0002);
      check("t1 reload", 16'(t1_count), 16'h0001);
      check("toggle 1", 16'(timer2_toggle_out), 16'h0001);
      repeat (16) @(negedge ref_clk);
      check("t2 waits t1", 16'(t2_count), 16'h0002);
      repeat (24) @(negedge ref_clk);
      check("t2 on t1 uf", 16'(t2_count), 16'h0001);
      check("t3 own source", 16'(t3_count < 8'h40), 16'h0001);
      wait_irq(1);
      check("toggle 2", 16'(timer2_toggle_out), 16'h0000);
      t8_ctrl.t2_wr_ctrl = 1'b1;
      wr8(2, 8'h05);
      check("t2 latch only", 16'(t2_count == 8'h05), 16'h0000);
      wait_irq(1);
      check("t2 latch taken", 16'(t2_count), 16'h0005);
      // Slow source: at most one step in 200 cycles
      t8_ctrl.t1_src = T1_SRC_DIV256;
      wr8(1, 8'h40);
      repeat (200) @(negedge ref_clk);
      check("t1 div256", 16'(t1_count >= 8'h3F), 16'h0001);
      report_and_stop();
   end
endmodule : tb_multimode_timer_set
`default_nettype wire
